// ### rtl/io_exp_pkg.sv
/*
 * Shared constants for the serial I/O expander: the slave address, the
 * register pointer codes and reset values of the device end, and the
 * command register map and link timing of the controller end.
 * Assumes both ends run on one 250 MHz clock and import this package.
 */
package io_exp_pkg;

    localparam int unsigned PORT_W = 8;

    // Fixed upper nibble of the 7-bit slave address
    localparam logic [3:0] DEV_ADDR_HI = 4'h4;

    // Pointer codes, low two bits of the command byte
    localparam logic [1:0] REG_PIN_INPUT   = 2'h0;
    localparam logic [1:0] REG_OUT_LATCH   = 2'h1;
    localparam logic [1:0] REG_INVERT      = 2'h2;
    localparam logic [1:0] REG_DIRECTION   = 2'h3;

    localparam logic [7:0] OUT_LATCH_RST   = 8'hFF;
    localparam logic [7:0] INVERT_RST      = 8'h00;
    localparam logic [7:0] DIRECTION_RST   = 8'hFF;
    localparam logic [7:0] POINTER_RST     = 8'h00;

    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

    // Link clock made by the controller, derived from the system clock
    localparam int unsigned CLK_PERIOD_NS   = 4;
    localparam int unsigned SCL_PERIOD_NS   = 64;
    localparam int unsigned SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

    // Controller command registers, byte addresses on the Wishbone bus
    localparam logic [3:0] WB_CMD          = 4'h0;
    localparam logic [3:0] WB_TXDATA       = 4'h4;
    localparam logic [3:0] WB_RXDATA       = 4'h8;
    localparam logic [3:0] WB_STATUS       = 4'hC;

    localparam logic [1:0] OP_START        = 2'h0;
    localparam logic [1:0] OP_WRITE        = 2'h1;
    localparam logic [1:0] OP_READ         = 2'h2;
    localparam logic [1:0] OP_STOP         = 2'h3;

    localparam int unsigned CMD_NACK_BIT   = 2;
    localparam int unsigned STAT_BUSY_BIT  = 0;
    localparam int unsigned STAT_NACK_BIT  = 1;

endpackage

// ### rtl/i2c_link_if.sv
/*
 * Two-wire link between the controller and the expander.
 * Both lines are open drain with a pull-up: a line is low while any
 * enabled driver pulls it low, otherwise high.
 */
`timescale 1ns/10ps
`default_nettype none

interface i2c_link_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    assign scl = ~(m_scl_oe & ~m_scl_o);
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

    modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                    input scl, input sda);
    modport device (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

`default_nettype wire

// ### rtl/io_expander_dev.sv
/*
 * Device end: serial slave and register file of an 8-bit I/O expander.
 * Assumes the link lines and port pins are asynchronous to clk_i and the
 * link clock is slow enough to be oversampled (several clk_i per phase).
 */
`timescale 1ns/10ps
`default_nettype none

module io_expander_dev
    import io_exp_pkg::*;
(
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    i2c_link_if.device                          link,
    input  wire logic                           addr_strap_0_i,
    input  wire logic                           addr_strap_1_i,
    input  wire logic                           addr_strap_2_i,
    input  wire logic [io_exp_pkg::PORT_W-1:0]  port_pins_i,
    output logic      [io_exp_pkg::PORT_W-1:0]  port_pins_o,
    output logic      [io_exp_pkg::PORT_W-1:0]  port_pins_oe_o,
    output logic                                int_n_o,
    output logic                                int_n_oe_o
);
    import io_exp_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX     = 3'b011,
        ST_TX_ACK = 3'b100,
        ST_IGNORE = 3'b101
    } dev_state_type;

    dev_state_type state_r;

    logic       scl_m_r, scl_s_r, scl_d_r;
    logic       sda_m_r, sda_s_r, sda_d_r;
    logic [2:0] strap_m_r, strap_s_r;
    logic [7:0] pins_m_r, pins_s_r;

    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [3:0] bit_cnt_r;
    logic [1:0] byte_idx_r;
    logic       rw_r;
    logic       nack_r;
    logic       sda_low_r;

    logic [7:0] pointer_r;
    logic [7:0] out_latch_r;
    logic [7:0] invert_r;
    logic [7:0] direction_r;
    logic [7:0] capture_r;
    logic       int_r;

    logic       scl_rise, scl_fall, start_det, stop_det;
    logic       addr_hit, byte_done, capture_evt;
    logic [7:0] rd_byte;

    function automatic logic [7:0] reg_read(input logic [1:0] sel,
                                            input logic [7:0] cap,
                                            input logic [7:0] inv,
                                            input logic [7:0] lat,
                                            input logic [7:0] dir);
        logic [7:0] val;
        val = 8'h00;
        case (sel)
            REG_PIN_INPUT: val = cap ^ inv;
            REG_OUT_LATCH: val = lat;
            REG_INVERT:    val = inv;
            REG_DIRECTION: val = dir;
            default:       val = 8'h00;
        endcase
        return val;
    endfunction

    // Two-flop synchronisers; a third stage on the lines gives edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_m_r <= link.scl;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= link.sda;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    always_ff @(posedge clk_i) begin
        strap_m_r <= {addr_strap_2_i, addr_strap_1_i, addr_strap_0_i};
        strap_s_r <= strap_m_r;
        pins_m_r  <= port_pins_i;
        pins_s_r  <= pins_m_r;
    end

    always_comb begin
        scl_rise    = scl_s_r & ~scl_d_r;
        scl_fall    = ~scl_s_r & scl_d_r;
        start_det   = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
        stop_det    = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
        addr_hit    = (shift_r[7:1] == {DEV_ADDR_HI, strap_s_r});
        byte_done   = (state_r == ST_RX) && scl_fall && (bit_cnt_r == BITS_PER_BYTE);
        // Captures only while the pointer selects the input register, so other pointers leave it and the interrupt alone
        capture_evt = scl_rise && (pointer_r[1:0] == REG_PIN_INPUT) &&
                      (((state_r == ST_RX_ACK) && rw_r) || (state_r == ST_TX_ACK));
        rd_byte     = reg_read(pointer_r[1:0], capture_r, invert_r, out_latch_r, direction_r);
    end

    // Serial machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= ST_IDLE;
            shift_r    <= 8'h00;
            tx_r       <= 8'h00;
            bit_cnt_r  <= 4'h0;
            byte_idx_r <= 2'h0;
            rw_r       <= 1'b0;
            nack_r     <= 1'b0;
            sda_low_r  <= 1'b0;
        end else if (start_det) begin
            // Start or repeated start; the pointer is left as it was
            state_r    <= ST_RX;
            bit_cnt_r  <= 4'h0;
            byte_idx_r <= 2'h0;
            sda_low_r  <= 1'b0;
        end else if (stop_det) begin
            state_r   <= ST_IDLE;
            sda_low_r <= 1'b0;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (scl_rise && bit_cnt_r < BITS_PER_BYTE) begin
                        shift_r   <= {shift_r[6:0], sda_s_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        if (byte_idx_r == 2'h0 && !addr_hit) begin
                            state_r <= ST_IGNORE;
                        end else begin
                            state_r   <= ST_RX_ACK;
                            sda_low_r <= 1'b1;
                            if (byte_idx_r == 2'h0) begin
                                rw_r <= shift_r[0];
                            end
                            if (byte_idx_r != 2'h2) begin
                                byte_idx_r <= byte_idx_r + 2'h1;
                            end
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            state_r   <= ST_TX;
                            sda_low_r <= ~rd_byte[7];
                            tx_r      <= {rd_byte[6:0], 1'b0};
                            bit_cnt_r <= 4'h1;
                        end else begin
                            state_r   <= ST_RX;
                            sda_low_r <= 1'b0;
                            bit_cnt_r <= 4'h0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == BITS_PER_BYTE) begin
                            state_r   <= ST_TX_ACK;
                            sda_low_r <= 1'b0;
                        end else begin
                            sda_low_r <= ~tx_r[7];
                            tx_r      <= {tx_r[6:0], 1'b0};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        nack_r <= sda_s_r;
                    end else if (scl_fall) begin
                        if (nack_r) begin
                            state_r <= ST_IGNORE;
                        end else begin
                            state_r   <= ST_TX;
                            sda_low_r <= ~rd_byte[7];
                            tx_r      <= {rd_byte[6:0], 1'b0};
                            bit_cnt_r <= 4'h1;
                        end
                    end
                end
                ST_IGNORE: begin
                    sda_low_r <= 1'b0;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Pointer and writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pointer_r   <= POINTER_RST;
            out_latch_r <= OUT_LATCH_RST;
            invert_r    <= INVERT_RST;
            direction_r <= DIRECTION_RST;
        end else if (byte_done && !rw_r && byte_idx_r == 2'h1) begin
            pointer_r <= shift_r;
        end else if (byte_done && !rw_r && byte_idx_r == 2'h2) begin
            case (pointer_r[1:0])
                REG_OUT_LATCH: out_latch_r <= shift_r;
                REG_INVERT:    invert_r    <= shift_r;
                REG_DIRECTION: direction_r <= shift_r;
                default:       out_latch_r <= out_latch_r;
            endcase
        end
    end

    // Input capture: seeded from the pins so no interrupt follows reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_r <= pins_s_r;
        end else if (capture_evt) begin
            capture_r <= pins_s_r;
        end
    end

    // A change during the capturing acknowledge pulse can be swallowed by the capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_r <= 1'b0;
        end else begin
            int_r <= |((pins_s_r ^ capture_r) & direction_r);
        end
    end

    assign port_pins_o    = out_latch_r;
    assign port_pins_oe_o = ~direction_r;
    assign int_n_o        = 1'b0;
    assign int_n_oe_o     = int_r;
    assign link.s_sda_o   = 1'b0;
    assign link.s_sda_oe  = sda_low_r;

endmodule

`default_nettype wire

// ### rtl/io_expander_host.sv
/*
 * Controller end: Wishbone-commanded byte engine that masters the link.
 * Assumes a classic Wishbone master on clk_i and an expander that does
 * not stretch the clock; SCL is made here by dividing clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module io_expander_host
    import io_exp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    i2c_link_if.master       link
);
    import io_exp_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_START = 2'b01,
        H_BITS  = 2'b10,
        H_STOP  = 2'b11
    } host_state_type;

    localparam logic [7:0] QUARTER_LAST = 8'(SCL_QUARTER_CYC - 1);

    host_state_type state_r;
    logic [7:0] qcnt_r;
    logic       tick;
    logic [1:0] phase_r;
    logic [3:0] bit_r;
    logic [7:0] tx_r, shift_r, rx_r;
    logic       is_read_r, nack_req_r, got_nack_r;
    logic       scl_low_r, sda_low_r;
    logic       sda_m_r, sda_s_r;
    logic       ack_r, wb_go, cmd_go;

    assign wb_go  = wb_cyc_i & wb_stb_i & ~ack_r;
    assign cmd_go = wb_go & wb_we_i & wb_sel_i[0] & (wb_adr_i == WB_CMD) & (state_r == H_IDLE);
    assign tick   = (qcnt_r == QUARTER_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
        end else begin
            sda_m_r <= link.sda;
            sda_s_r <= sda_m_r;
        end
    end

    // Quarter-period divider, restarted by each command
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_go || tick) begin
            qcnt_r <= 8'h00;
        end else begin
            qcnt_r <= qcnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            tx_r     <= 8'h00;
        end else begin
            ack_r <= wb_go;
            if (wb_go && wb_we_i && wb_sel_i[0] && wb_adr_i == WB_TXDATA) begin
                tx_r <= wb_dat_i[7:0];
            end
            if (wb_go) begin
                case (wb_adr_i)
                    WB_TXDATA: wb_dat_o <= {24'h00_0000, tx_r};
                    WB_RXDATA: wb_dat_o <= {24'h00_0000, rx_r};
                    WB_STATUS: wb_dat_o <= {30'h0000_0000, got_nack_r, state_r != H_IDLE};
                    default:   wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign wb_ack_o = ack_r;

    // Each bit is four quarters: low, high, high (sample), low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= H_IDLE;
            phase_r    <= 2'h0;
            bit_r      <= 4'h0;
            shift_r    <= 8'hFF;
            rx_r       <= 8'h00;
            is_read_r  <= 1'b0;
            nack_req_r <= 1'b0;
            got_nack_r <= 1'b0;
            scl_low_r  <= 1'b0;
            sda_low_r  <= 1'b0;
        end else if (cmd_go) begin
            phase_r    <= 2'h0;
            bit_r      <= 4'h0;
            is_read_r  <= (wb_dat_i[1:0] == OP_READ);
            nack_req_r <= wb_dat_i[CMD_NACK_BIT];
            shift_r    <= (wb_dat_i[1:0] == OP_WRITE) ? tx_r : 8'hFF;
            case (wb_dat_i[1:0])
                OP_START: state_r <= H_START;
                OP_STOP:  state_r <= H_STOP;
                default:  state_r <= H_BITS;
            endcase
        end else if (tick && state_r != H_IDLE) begin
            phase_r <= phase_r + 2'h1;
            case (state_r)
                H_START: begin
                    case (phase_r)
                        2'h0: begin
                            scl_low_r <= 1'b1;
                            sda_low_r <= 1'b0;
                        end
                        2'h1:    scl_low_r <= 1'b0;
                        2'h2:    sda_low_r <= 1'b1;
                        default: begin
                            scl_low_r <= 1'b1;
                            state_r   <= H_IDLE;
                        end
                    endcase
                end
                H_BITS: begin
                    case (phase_r)
                        2'h0: begin
                            scl_low_r <= 1'b1;
                            if (bit_r < BITS_PER_BYTE) begin
                                sda_low_r <= ~shift_r[7];
                            end else begin
                                sda_low_r <= is_read_r & ~nack_req_r;
                            end
                        end
                        2'h1: scl_low_r <= 1'b0;
                        2'h2: begin
                            if (bit_r < BITS_PER_BYTE) begin
                                rx_r    <= {rx_r[6:0], sda_s_r};
                                shift_r <= {shift_r[6:0], 1'b1};
                            end else if (!is_read_r) begin
                                got_nack_r <= sda_s_r;
                            end
                        end
                        default: begin
                            scl_low_r <= 1'b1;
                            bit_r     <= bit_r + 4'h1;
                            if (bit_r == BITS_PER_BYTE) begin
                                state_r <= H_IDLE;
                            end
                        end
                    endcase
                end
                H_STOP: begin
                    case (phase_r)
                        2'h0: begin
                            scl_low_r <= 1'b1;
                            sda_low_r <= 1'b1;
                        end
                        2'h1:    scl_low_r <= 1'b0;
                        2'h2:    sda_low_r <= 1'b0;
                        default: state_r <= H_IDLE;
                    endcase
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end

    assign link.m_scl_o  = 1'b0;
    assign link.m_scl_oe = scl_low_r;
    assign link.m_sda_o  = 1'b0;
    assign link.m_sda_oe = sda_low_r;

endmodule

`default_nettype wire

// ### bench/io_exp_link_properties.sv
/* Link checker: timing and ownership rules on the two-wire link.
   Assumes instantiation beside the interface, one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module io_exp_link_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic m_scl_o,
    input wire logic m_scl_oe,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    idle_release_a: assert property ($fell(rst_i) |-> scl && sda)
        else $error("link not idle after reset");
    scl_high_a: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high phase too short");
    scl_low_a: assert property ($fell(scl) |-> (!scl)[*4])
        else $error("clock low phase too short");
    data_stable_a: assert property ($rose(scl) |=> $stable(sda)[*3])
        else $error("data moved in clock high phase");
    dev_change_a: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("expander moved data while clock high");
    ctrl_only_a: assert property (scl && $changed(sda) |-> $changed(m_sda_oe))
        else $error("control condition not made by controller");
    ack_hold_a: assert property ($rose(scl) && s_sda_oe |-> s_sda_oe[*8])
        else $error("acknowledge not held through high phase");
    stop_idle_a: assert property (scl && $rose(sda) |=> scl && sda)
        else $error("link not idle after stop");
    release_bound_a: assert property ($rose(s_sda_oe) |-> ##[1:200] !s_sda_oe)
        else $error("expander kept data line");

    cover property (scl && $fell(sda));
    cover property (scl && $rose(sda));
    cover property ($rose(scl) && s_sda_oe);
endmodule
`default_nettype wire

// ### bench/i2c_io_expander_registers_tb_top.sv
/* Bench: controller and expander joined over the link, run by Wishbone.
   Assumes the package constants and a 250 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module i2c_io_expander_registers_tb_top;
    import io_exp_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [2:0]  strap = 3'h0;
    logic [7:0]  pins = 8'h00;
    logic [7:0]  pins_o;
    logic [7:0]  pins_oe;
    logic        int_oe;
    logic        int_lvl;
    logic [6:0]  dev;
    logic [7:0]  lat = 8'hFF;
    logic [7:0]  inv = 8'h00;
    logic [7:0]  dir = 8'hFF;
    logic [31:0] lfsr = 32'hCDBD191B;
    logic [7:0]  exp_q[$];
    logic        scl_d = 1'b1;
    int          rises = 0;
    int          mismatches = 0;
    int          total_checks = 0;

    assign dev = {DEV_ADDR_HI, strap};
    always #2 clk_i = ~clk_i;

    i2c_link_if link ();
    io_expander_host i_io_expander_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .link(link.master));
    io_expander_dev i_io_expander_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link.device),
        .addr_strap_0_i(strap[0]), .addr_strap_1_i(strap[1]), .addr_strap_2_i(strap[2]),
        .port_pins_i(pins), .port_pins_o(pins_o), .port_pins_oe_o(pins_oe), .int_n_o(int_lvl),
        .int_n_oe_o(int_oe));
    io_exp_link_properties i_io_exp_link_properties (.clk_i(clk_i), .rst_i(rst_i),
        .m_scl_o(link.m_scl_o), .m_scl_oe(link.m_scl_oe), .m_sda_o(link.m_sda_o),
        .m_sda_oe(link.m_sda_oe), .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe),
        .scl(link.scl), .sda(link.sda));

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask

    function automatic logic [7:0] exp_reg(input logic [1:0] p);
        case (p)
            REG_PIN_INPUT: return pins ^ inv;
            REG_OUT_LATCH: return lat;
            REG_INVERT:    return inv;
            default:       return dir;
        endcase
    endfunction

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Counts link clock rises so each byte sent with put can be checked for nine slots
    always @(posedge clk_i) begin
        scl_d <= link.scl;
        if (link.scl && !scl_d)
            rises++;
        if (ack === 1'b1 && cyc && !we && adr == WB_RXDATA && exp_q.size() > 0)
            chk("read byte", rdat[7:0], exp_q.pop_front());
    end

    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (ack !== 1'b1) begin
            mismatches++;
            conclude();
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        we <= 1'b0;
    endtask

    // Polls busy after every command; the engine ignores commands while busy
    task automatic op(input logic [1:0] o, input logic nk, output logic [7:0] q);
        int n;
        wb(1'b1, WB_CMD, {5'h0, nk, o}, q);
        n = 0;
        do begin
            wb(1'b0, WB_STATUS, 8'h00, q);
            n++;
        end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 500);
        if (q[STAT_BUSY_BIT] !== 1'b0) begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic put(input logic [7:0] b, input logic nk);
        logic [7:0] q;
        wb(1'b1, WB_TXDATA, b, q);
        rises = 0;
        op(OP_WRITE, 1'b0, q);
        chk("ack bit", {7'h0, q[STAT_NACK_BIT]}, {7'h0, nk});
        chk("clock count", 8'(rises), 8'h09);
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] q;
        op(OP_START, 1'b0, q);
        put({dev, 1'b0}, 1'b0);
        put(p, 1'b0);
        put(d, 1'b0);
        op(OP_STOP, 1'b0, q);
    endtask

    task automatic rd(input logic [7:0] p, input logic cmd);
        logic [7:0] q;
        if (cmd) begin
            op(OP_START, 1'b0, q);
            put({dev, 1'b0}, 1'b0);
            put(p, 1'b0);
        end
        op(OP_START, 1'b0, q);
        put({dev, 1'b1}, 1'b0);
        for (int i = 0; i < 2; i++) begin
            op(OP_READ, 1'(i), q);
            exp_q.push_back(exp_reg(p[1:0]));
            wb(1'b0, WB_RXDATA, 8'h00, q);
        end
        op(OP_STOP, 1'b0, q);
    endtask

    task automatic irq_after(input logic [7:0] flip, input logic want);
        pins <= pins ^ flip;
        repeat (5) @(posedge clk_i);
        chk("interrupt", {7'h0, int_oe}, {7'h0, want});
    endtask

    initial begin
        logic [7:0] q;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("pin enable", pins_oe, 8'h00);
        chk("pin drive", pins_o, 8'hFF);
        chk("interrupt", {7'h0, int_oe}, 8'h00);
        chk("interrupt level", {7'h0, int_lvl}, 8'h00);
        for (int s = 0; s < 8; s++) begin
            strap <= 3'(s);
            repeat (4) @(posedge clk_i);
            op(OP_START, 1'b0, q);
            put({dev ^ 7'h01, 1'b0}, 1'b1);
            put(8'h01, 1'b1);
            op(OP_STOP, 1'b0, q);
            rd(8'(s % 4), 1'b1);
        end
        $display("test addresses and defaults done");
        for (int k = 0; k < 2; k++) begin
            lfsr = lfsr_next(lfsr);
            pins <= lfsr[7:0];
            lat = lfsr[15:8];
            inv = lfsr[23:16];
            dir = lfsr[31:24];
            wr(8'h01, lat);
            wr(8'h02, inv);
            wr(8'h03, dir);
            chk("pin drive", pins_o, lat);
            chk("pin enable", pins_oe, ~dir);
            for (int r = 0; r < 4; r++)
                rd(8'(r), 1'b1);
            rd(8'h03, 1'b0);
        end
        wr(8'h00, ~pins);
        rd(8'h00, 1'b1);
        $display("test register access done");
        dir = 8'h0F;
        wr(8'h03, dir);
        rd(8'h00, 1'b1);
        irq_after(8'hF0, 1'b0);
        irq_after(8'h01, 1'b1);
        irq_after(8'h01, 1'b0);
        irq_after(8'h02, 1'b1);
        rd(8'h00, 1'b0);
        chk("interrupt", {7'h0, int_oe}, 8'h00);
        $display("test interrupt done");
        chk("pending reads", 8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
